// [logic/cwg_pkg.sv]
// Register map, field positions, mode codes and bus carrier for the core.
package cwg_pkg;
    localparam logic [7:0] OFS_PRIMARY = 8'h00;
    localparam logic [7:0] OFS_POLARITY = 8'h04;
    localparam logic [7:0] OFS_RISE_DB = 8'h08;
    localparam logic [7:0] OFS_FALL_DB = 8'h0c;
    localparam logic [7:0] OFS_SHUTDOWN = 8'h10;
    localparam logic [7:0] OFS_SRC_SEL = 8'h14;
    localparam logic [7:0] OFS_STEERING = 8'h18;
    localparam logic [7:0] OFS_CLK_SEL = 8'h1c;
    localparam int EN_BIT = 7;
    localparam int LD_BIT = 6;
    localparam int IN_BIT = 5;
    localparam int SD_BIT = 7;
    localparam int REN_BIT = 6;
    localparam int OVERRIDE_LEVEL_SECOND_PAIR_LSB = 4;
    localparam int OVERRIDE_LEVEL_FIRST_PAIR_LSB = 2;
    localparam int LVL_LSB = 4;
    localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
    localparam logic [2:0] MODE_STEER_SYNC = 3'h1;
    localparam logic [2:0] MODE_FB_FWD = 3'h2;
    localparam logic [2:0] MODE_FB_REV = 3'h3;
    localparam logic [2:0] MODE_HALF = 3'h4;
    localparam logic [2:0] MODE_PUSH = 3'h5;
    localparam logic [1:0] OVERRIDE_LEVEL_SECOND_PAIR_RST = 2'h1;
    localparam logic [1:0] OVERRIDE_LEVEL_FIRST_PAIR_RST = 2'h1;
    localparam int ACT_TIMEOUT_DEF = 255;
    localparam int DB_W_DEF = 6;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;
endpackage : cwg_pkg

// [logic/cwg_core.sv]
// Complementary waveform core: dead band, steering, shutdown, bus slave.
`timescale 1ns/100ps
// Behaviour
// R01 - Rising value delays A (half) or B (full); falling delays B or D.
// R02 - Dead-band values double-buffered; loaded at once while disabled.
// R03 - When enabled, load request moves buffers at next input fall.
// R04 - Input phase shorter than dead band gives no output pulse.
// R05 - Asynchronous input edges vary dead band by one clock at most.
// R06 - Direction bit writable anytime, takes effect at next input rise.
// R07 - On direction change A/C switch at rise; new output waits dead band.
// R08 - Steering lets any set of the four outputs carry the input.
// R09 - Steer bit 0 holds the fixed level; bit 1 passes the input.
// R10 - Polarity applies only to outputs whose steer bit is set.
// R11 - In steering, shutdown overrides only the steered outputs.
// R12 - Mode 000 applies steering changes right after the write.
// R13 - Mode 001 applies steering changes at next input rise.
// R14 - Software set shutdown bit holds shutdown while it stays set.
// R15 - With auto-restart the bit clears itself; output resumes on rise.
// R16 - Active selected fault drives override levels with no software.
// R17 - Six active-low fault sources, each individually selectable.
// R18 - Faults are level sensed; shutdown stays while one is active.
// R19 - Fast oscillator kept on when selected, enabled and input active.
// R20 - Override fields set B/D and A/C levels; polarity ignored.
// R21 - Without auto-restart, software clear works only with no fault.
// R22 - Overrides stay after clear until the first input rise.
// R23 - Software programs overrides and sets shutdown before enabling.
// R24 - Mode codes 000 to 101 as listed; 110 and 111 reserved.
// R25 - Two 6-bit counters count clock periods up to the value.
// R26 - Load request cleared by hardware; set only when already enabled.
// R27 - Auto-restart clears shutdown once all selected faults are gone.
// R28 - Hardware sets shutdown bit whenever a selected fault is active.
//////////////////////////////////////////////////////////////////////////////
module cwg_core #(
    parameter int DB_W = cwg_pkg::DB_W_DEF,
    parameter int ACT_TIMEOUT = cwg_pkg::ACT_TIMEOUT_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire cwg_pkg::wb_req_t wb_req,
    output logic wb_ack,
    output logic [31:0] wb_dat_o,
    input wire logic data_in,
    input wire logic [5:0] fault_n,
    output logic [3:0] drive,
    output logic fast_osc_sel,
    output logic fast_osc_keep
);
    localparam int ACT_W = $clog2(ACT_TIMEOUT + 1);

    generate
        if (DB_W < 1 || DB_W > 8)
            $error("DB_W must lie between 1 and 8");
        if (ACT_TIMEOUT < 1)
            $error("ACT_TIMEOUT must be at least 1");
    endgenerate

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    function automatic logic [7:0] pad8(input logic [DB_W-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        r[DB_W-1:0] = v;
        return r;
    endfunction : pad8

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: input data in bit 0, fault sources above it.
    logic [6:0] meta_ff;
    logic [6:0] sync_ff;
    logic in_d_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= 7'h7e;
            sync_ff <= 7'h7e;
            in_d_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= {fault_n, data_in};
            sync_ff <= meta_ff;
            in_d_ff <= sync_ff[0];
        end
    end

    // Sampling both edges on this clock bounds the delay jitter to one
    // clock period. R05
    wire in_s = sync_ff[0];
    wire rise = in_s & ~in_d_ff;
    wire fall = ~in_s & in_d_ff;

    //////////////////////////////////////////////////////////////////////////
    // Bus slave: ack one cycle after the request, writes at the ack edge.
    logic ack_ff;
    logic [31:0] dat_ff;
    logic en_ff;
    logic ld_ff;
    logic [2:0] mode_ff;
    logic [3:0] pol_ff;
    logic [DB_W-1:0] dbr_buf_ff;
    logic [DB_W-1:0] dbf_buf_ff;
    logic [DB_W-1:0] dbr_act_ff;
    logic [DB_W-1:0] dbf_act_ff;
    logic sd_ff;
    logic ren_ff;
    logic [1:0] override_level_second_pair_ff;
    logic [1:0] override_level_first_pair_ff;
    logic [5:0] src_ff;
    logic [3:0] str_ff;
    logic [3:0] lvl_ff;
    logic clk_sel_ff;

    wire bus_req = wb_req.cyc & wb_req.stb;
    wire wr_fire = bus_req & wb_req.we & ack_ff & wb_req.sel[0];
    wire [7:0] wdat = wb_req.dat[7:0];
    wire [7:0] adr = wb_req.adr;
    wire wr_pri = wr_fire & hit(adr, cwg_pkg::OFS_PRIMARY);
    wire wr_pol = wr_fire & hit(adr, cwg_pkg::OFS_POLARITY);
    wire wr_dbr = wr_fire & hit(adr, cwg_pkg::OFS_RISE_DB);
    wire wr_dbf = wr_fire & hit(adr, cwg_pkg::OFS_FALL_DB);
    wire wr_sdc = wr_fire & hit(adr, cwg_pkg::OFS_SHUTDOWN);
    wire wr_src = wr_fire & hit(adr, cwg_pkg::OFS_SRC_SEL);
    wire wr_str = wr_fire & hit(adr, cwg_pkg::OFS_STEERING);
    wire wr_clk = wr_fire & hit(adr, cwg_pkg::OFS_CLK_SEL);

    wire [7:0] rd_byte =
        hit(adr, cwg_pkg::OFS_PRIMARY) ? {en_ff, ld_ff, 3'h0, mode_ff} :
        hit(adr, cwg_pkg::OFS_POLARITY) ? {2'h0, in_s, 1'b0, pol_ff} :
        hit(adr, cwg_pkg::OFS_RISE_DB) ? pad8(dbr_buf_ff) :
        hit(adr, cwg_pkg::OFS_FALL_DB) ? pad8(dbf_buf_ff) :
        hit(adr, cwg_pkg::OFS_SHUTDOWN) ?
            {sd_ff, ren_ff, override_level_second_pair_ff, override_level_first_pair_ff, 2'h0} :
        hit(adr, cwg_pkg::OFS_SRC_SEL) ? {2'h0, src_ff} :
        hit(adr, cwg_pkg::OFS_STEERING) ? {lvl_ff, str_ff} :
        hit(adr, cwg_pkg::OFS_CLK_SEL) ? {7'h00, clk_sel_ff} :
        8'h00;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= bus_req & ~ack_ff;
            if (bus_req && !ack_ff)
                dat_ff <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack = ack_ff;
    assign wb_dat_o = dat_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            en_ff <= 1'b0;
            mode_ff <= cwg_pkg::MODE_STEER_ASYNC;
            pol_ff <= 4'h0;
            dbr_buf_ff <= '0;
            dbf_buf_ff <= '0;
            ren_ff <= 1'b0;
            override_level_second_pair_ff <= cwg_pkg::OVERRIDE_LEVEL_SECOND_PAIR_RST;
            override_level_first_pair_ff <= cwg_pkg::OVERRIDE_LEVEL_FIRST_PAIR_RST;
            src_ff <= 6'h00;
            str_ff <= 4'h0;
            lvl_ff <= 4'h0;
            clk_sel_ff <= 1'b0;
        end
        else
        begin
            if (wr_pri)
            begin
                en_ff <= wdat[cwg_pkg::EN_BIT];
                mode_ff <= wdat[2:0];
            end
            if (wr_pol)
                pol_ff <= wdat[3:0];
            if (wr_dbr)
                dbr_buf_ff <= wdat[DB_W-1:0];
            if (wr_dbf)
                dbf_buf_ff <= wdat[DB_W-1:0];
            if (wr_sdc)
            begin
                ren_ff <= wdat[cwg_pkg::REN_BIT];
                override_level_second_pair_ff <= wdat[cwg_pkg::OVERRIDE_LEVEL_SECOND_PAIR_LSB +: 2];
                override_level_first_pair_ff <= wdat[cwg_pkg::OVERRIDE_LEVEL_FIRST_PAIR_LSB +: 2];
            end
            if (wr_src)
                src_ff <= wdat[5:0]; // R17
            if (wr_str)
            begin
                str_ff <= wdat[3:0];
                lvl_ff <= wdat[cwg_pkg::LVL_LSB +: 4];
            end
            if (wr_clk)
                clk_sel_ff <= wdat[0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Dead-band buffers and load request.
    wire ld_set = wr_pri & wdat[cwg_pkg::LD_BIT] & en_ff; // R26
    wire ld_take = en_ff & ld_ff & fall; // R03
    // A set arriving with the load keeps the request pending.
    wire nxt_ld = ld_set | (ld_ff & en_ff & ~fall); // R26

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ld_ff <= 1'b0;
            dbr_act_ff <= '0;
            dbf_act_ff <= '0;
        end
        else
        begin
            ld_ff <= nxt_ld;
            if (!en_ff || ld_take) // R02 R03
            begin
                dbr_act_ff <= dbr_buf_ff;
                dbf_act_ff <= dbf_buf_ff;
            end
        end
    end

    // One counter runs while the input is high, the other while it is low;
    // both saturate so a long phase cannot wrap back under the value.
    logic [DB_W-1:0] cnt_hi_ff;
    logic [DB_W-1:0] cnt_lo_ff;
    wire [DB_W-1:0] cnt_max = '1;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_hi_ff <= '0;
            cnt_lo_ff <= '0;
        end
        else
        begin
            cnt_hi_ff <= !in_s ? '0 :
                (cnt_hi_ff == cnt_max ? cnt_hi_ff : cnt_hi_ff + 1'b1); // R25
            cnt_lo_ff <= in_s ? '0 :
                (cnt_lo_ff == cnt_max ? cnt_lo_ff : cnt_lo_ff + 1'b1); // R25
        end
    end

    wire hi_r_done = cnt_hi_ff >= dbr_act_ff;
    wire hi_f_done = cnt_hi_ff >= dbf_act_ff;
    wire lo_f_done = cnt_lo_ff >= dbf_act_ff;

    //////////////////////////////////////////////////////////////////////////
    // Mode decode, direction, push-pull sequencer, steering shadow.
    wire is_steer = (mode_ff == cwg_pkg::MODE_STEER_ASYNC) |
                    (mode_ff == cwg_pkg::MODE_STEER_SYNC); // R24
    wire is_fb = (mode_ff == cwg_pkg::MODE_FB_FWD) |
                 (mode_ff == cwg_pkg::MODE_FB_REV); // R24
    wire is_half = mode_ff == cwg_pkg::MODE_HALF; // R24
    wire is_push = mode_ff == cwg_pkg::MODE_PUSH; // R24

    logic dir_ff;
    logic chg_ff;
    logic pp_ff;
    logic [3:0] str_act_ff;
    logic [3:0] lvl_act_ff;
    wire ovr_now;

    wire fb_rise = rise & is_fb;
    // Use the new direction in the very rise cycle so that the old
    // modulated output gives no stray pulse. R06 R07
    wire dir_now = fb_rise ? mode_ff[0] : dir_ff;
    wire chg_now = fb_rise ? (mode_ff[0] != dir_ff) : chg_ff;
    wire str_upd = (mode_ff != cwg_pkg::MODE_STEER_SYNC) | rise; // R12 R13

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dir_ff <= 1'b0;
            chg_ff <= 1'b0;
            pp_ff <= 1'b0;
            str_act_ff <= 4'h0;
            lvl_act_ff <= 4'h0;
        end
        else
        begin
            dir_ff <= dir_now; // R06
            chg_ff <= chg_now & ~fall; // R07
            pp_ff <= (!en_ff || ovr_now) ? 1'b0 : (pp_ff ^ fall);
            if (str_upd)
            begin
                str_act_ff <= str_ff;
                lvl_act_ff <= lvl_ff;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Shutdown state and override hold.
    wire fault_any = |(~sync_ff[6:1] & src_ff); // R17 R18
    wire sw_sd_set = wr_sdc & wdat[cwg_pkg::SD_BIT]; // R14
    wire sw_sd_clr = wr_sdc & ~wdat[cwg_pkg::SD_BIT] & ~ren_ff &
                     ~fault_any; // R21
    wire auto_clr = ren_ff & ~fault_any; // R15 R27
    // Setting sources win over every clear.
    wire nxt_sd = fault_any | sw_sd_set |
                  (sd_ff & ~sw_sd_clr & ~auto_clr); // R28 R14 R18
    logic ovr_ff;
    assign ovr_now = ovr_ff | sd_ff | fault_any; // R16
    // Disabled sets the override hold, so every start begins overridden. R23
    wire nxt_ovr = ~en_ff | sd_ff | fault_any | (ovr_ff & ~rise); // R22

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sd_ff <= 1'b0;
            ovr_ff <= 1'b1;
        end
        else
        begin
            sd_ff <= nxt_sd;
            ovr_ff <= nxt_ovr;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Waveforms in {D, C, B, A} order, then polarity and override.
    wire hb_a = in_s & hi_r_done; // R01 R04
    wire hb_b = ~in_s & lo_f_done; // R01 R04
    wire fb_ok = ~chg_now | (dir_now ? hi_r_done : hi_f_done); // R01 R07
    wire fb_mod = in_s & fb_ok;
    wire [3:0] fb_wave = dir_now ? {1'b0, 1'b1, fb_mod, 1'b0} :
                                   {fb_mod, 1'b0, 1'b0, 1'b1};
    wire pp_a = in_s & ~pp_ff;
    wire pp_b = in_s & pp_ff;
    wire [3:0] wave = is_fb ? fb_wave :
                      is_half ? {hb_b, hb_a, hb_b, hb_a} :
                      is_push ? {pp_b, pp_a, pp_b, pp_a} :
                      4'h0;
    // Steered outputs carry the input with polarity; others hold level.
    wire [3:0] steer_norm = (str_act_ff & ({4{in_s}} ^ pol_ff)) |
                            (~str_act_ff & lvl_act_ff); // R08 R09 R10
    wire [3:0] norm = is_steer ? steer_norm :
                      (is_fb | is_half | is_push) ? (wave ^ pol_ff) :
                      4'h0;
    wire [3:0] ovr_lvl = {override_level_second_pair_ff[0], override_level_first_pair_ff[0],
                          override_level_second_pair_ff[1], override_level_first_pair_ff[1]}; // R20
    wire [3:0] affected = is_steer ? str_act_ff : 4'hf; // R11
    wire [3:0] nxt_out = !en_ff ? 4'h0 :
        !ovr_now ? norm :
        (affected & ovr_lvl) | (~affected & norm); // R16 R20

    logic [3:0] out_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            out_ff <= 4'h0;
        else
            out_ff <= nxt_out;
    end

    assign drive = out_ff;

    //////////////////////////////////////////////////////////////////////////
    // Sleep support: keep the fast oscillator while the input toggles.
    logic [ACT_W-1:0] act_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            act_ff <= '0;
        else if (rise || fall)
            act_ff <= ACT_W'(ACT_TIMEOUT);
        else if (act_ff != '0)
            act_ff <= act_ff - 1'b1;
    end

    assign fast_osc_sel = clk_sel_ff;
    assign fast_osc_keep = en_ff & clk_sel_ff & (act_ff != '0); // R19

    //////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    ld_set_a: // R26
    assert property ($rose(ld_ff) |-> $past(en_ff))
        else $error("load request set while module was disabled");
    db_load_a: // R03
    assert property (ld_take |=> dbr_act_ff == $past(dbr_buf_ff) &&
                     dbf_act_ff == $past(dbf_buf_ff))
        else $error("dead-band buffers not moved at input fall");
    db_idle_a: // R02
    assert property (!en_ff ##1 !en_ff |-> dbr_act_ff == $past(dbr_buf_ff))
        else $error("disabled dead-band value not loaded at once");
    sd_hold_a: // R21
    assert property (sd_ff && fault_any && !ren_ff |=> sd_ff)
        else $error("shutdown cleared while a fault stays active");
    fault_set_a: // R28
    assert property ($fell(sync_ff[1]) && src_ff[0] |=> sd_ff)
        else $error("selected fault did not set the shutdown bit");
    auto_clr_a: // R27
    assert property (sd_ff && ren_ff && !fault_any && !sw_sd_set
                     |=> !sd_ff)
        else $error("auto-restart did not clear the shutdown bit");
    ovr_lvl_a: // R20
    assert property (en_ff && !is_steer && ovr_now
                     |=> drive == $past(ovr_lvl))
        else $error("override level wrong during shutdown");
    steer_fixed_a: // R09
    assert property (en_ff && is_steer |=>
                     ((drive ^ $past(lvl_act_ff)) & ~$past(str_act_ff)) ==
                     4'h0)
        else $error("unsteered output left its fixed level");
    hb_delay_a: // R04
    assert property (en_ff && is_half && !ovr_now && !pol_ff[0] &&
                     cnt_hi_ff < dbr_act_ff |=> !drive[0])
        else $error("half-bridge output rose inside dead band");
    ovr_hold_a: // R22
    assert property (en_ff && ovr_ff && !sd_ff && !fault_any && !rise
                     |=> ovr_ff)
        else $error("override released before an input rise");
    dir_hold_a: // R06
    assert property (!rise |=> $stable(dir_ff))
        else $error("direction changed away from an input rise");
    sync_steer_a: // R13
    assert property (mode_ff == cwg_pkg::MODE_STEER_SYNC && !rise
                     |=> $stable(str_act_ff))
        else $error("synchronous steering changed without input rise");
endmodule : cwg_core

// [tb/cwg_partner.sv]
// Model of the waveform source and the fault sources; it only watches the outputs.
`timescale 1ns/100ps
module cwg_partner (
    input wire logic clk,
    input wire logic [3:0] drive,
    output logic data_in,
    output logic [5:0] fault_n
);
    initial
    begin
        data_in = 1'b0;
        fault_n = 6'h3f;
    end

    //////////////////////////////////////////////////////////////////////
    // Faults are levels held for as long as the fault lasts, never pulses.
    task automatic set_fault(input logic [5:0] v);
        @(posedge clk);
        fault_n <= v;
    endtask : set_fault

    task automatic set_in(input logic v);
        @(posedge clk);
        data_in <= v;
    endtask : set_in

    // Holds the input high for hi cycles and reports the cycle in which
    // output i first showed high, or -1 if it never did in the window.
    task automatic pulse(input int i, input int hi, output int d);
        int k;
        d = -1;
        @(posedge clk);
        data_in <= 1'b1;
        for (k = 1; k <= hi + 16; k++)
        begin
            @(posedge clk);
            if (k == hi)
                data_in <= 1'b0;
            if (d < 0 && drive[i] === 1'b1)
                d = k;
        end
    endtask : pulse
endmodule : cwg_partner

// [tb/tb_top.sv]
// Self-checking testbench for the waveform core.
`timescale 1ns/100ps
module tb_top;
    logic clk;
    logic rstn;
    cwg_pkg::wb_req_t wb_req;
    logic wb_ack;
    logic [31:0] wb_dat_o;
    logic data_in;
    logic [5:0] fault_n;
    logic [3:0] drive;
    logic fast_osc_sel;
    logic fast_osc_keep;
    logic [31:0] rd;
    int n_errors;
    int tests_run;
    int d0;
    int d1;

    cwg_core #(.DB_W(6), .ACT_TIMEOUT(8)) uut (
        .clk(clk), .rstn(rstn), .wb_req(wb_req), .wb_ack(wb_ack),
        .wb_dat_o(wb_dat_o), .data_in(data_in), .fault_n(fault_n),
        .drive(drive), .fast_osc_sel(fast_osc_sel),
        .fast_osc_keep(fast_osc_keep)
    );
    cwg_partner far (
        .clk(clk), .drive(drive), .data_in(data_in), .fault_n(fault_n)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    //////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        n_errors++;
    endtask : fail

    // The request stands until ack is seen at an edge; read data is
    // taken at that same edge, then cyc and stb drop for a cycle.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int k;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s,
                    dat: d};
        for (k = 0; k < 20 && wb_ack !== 1'b1; k++)
            @(posedge clk);
        q = wb_dat_o;
        wb_req <= '0;
        if (k == 20)
        begin
            fail("bus answer missing");
            close_out();
        end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {4{d}}, 4'hf, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 32'h0000_0000, 4'hf, rd);
        tests_run++;
        if (rd !== {24'h00_0000, exp})
            fail($sformatf("reg %h read %h want %h", a, rd, exp));
    endtask : rdc

    task automatic chk_drv(input int wait_n, input logic [3:0] exp);
        repeat (wait_n) @(posedge clk);
        tests_run++;
        if (drive !== exp)
            fail($sformatf("outputs %b want %b", drive, exp));
    endtask : chk_drv

    task automatic chk_cnt(input logic signed [31:0] got,
                           input logic signed [31:0] exp);
        tests_run++;
        if (got !== exp)
            fail($sformatf("count %0d want %0d", got, exp));
    endtask : chk_cnt

    // Start always goes through the shutdown state, so overrides are
    // programmed and the first input rise releases them.
    task automatic start(input logic [2:0] mode, input logic [7:0] sd);
        int d;
        wr(cwg_pkg::OFS_PRIMARY, 8'h00);
        wr(cwg_pkg::OFS_SHUTDOWN, 8'h80 | sd);
        wr(cwg_pkg::OFS_PRIMARY, {5'h00, mode});
        // The enabling write also asks for a load, which must be refused.
        wr(cwg_pkg::OFS_PRIMARY, {5'h18, mode});
        rdc(cwg_pkg::OFS_PRIMARY, {5'h10, mode});
        wr(cwg_pkg::OFS_SHUTDOWN, sd);
        far.pulse(0, 2, d);
    endtask : start

    //////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc(cwg_pkg::OFS_SHUTDOWN, 8'h14);
        rdc(8'h20, 8'h00);
        // A write without the low byte lane selected must be ignored.
        wb(1'b1, cwg_pkg::OFS_RISE_DB, 32'h5a5a_a53f, 4'he, rd);
        rdc(cwg_pkg::OFS_RISE_DB, 8'h00);
        chk_drv(1, 4'h0);
    endtask : t_reset

    task automatic t_deadband;
        int d2;
        wr(cwg_pkg::OFS_RISE_DB, 8'h04);
        start(cwg_pkg::MODE_HALF, 8'h00);
        far.pulse(0, 30, d0);
        wr(cwg_pkg::OFS_RISE_DB, 8'h09);
        far.pulse(0, 30, d1);
        chk_cnt(d1, d0);
        wr(cwg_pkg::OFS_PRIMARY, 8'hc4);
        far.pulse(0, 30, d1);
        rdc(cwg_pkg::OFS_PRIMARY, 8'h84);
        far.pulse(0, 30, d2);
        chk_cnt(d2 - d0, 5);
        far.pulse(0, 6, d2);
        chk_cnt(d2, -1);
    endtask : t_deadband

    task automatic t_steer;
        wr(cwg_pkg::OFS_POLARITY, 8'h02);
        wr(cwg_pkg::OFS_STEERING, 8'hc3);
        start(cwg_pkg::MODE_STEER_ASYNC, 8'h00);
        far.set_in(1'b1);
        chk_drv(5, 4'hd);
        far.set_in(1'b0);
        chk_drv(5, 4'he);
        wr(cwg_pkg::OFS_STEERING, 8'h0f);
        chk_drv(4, 4'h2);
        wr(cwg_pkg::OFS_PRIMARY, 8'h81);
        wr(cwg_pkg::OFS_STEERING, 8'hc3);
        chk_drv(5, 4'h2);
        far.set_in(1'b1);
        chk_drv(5, 4'hd);
        far.set_in(1'b0);
        chk_drv(5, 4'he);
    endtask : t_steer

    task automatic t_shutdown;
        wr(cwg_pkg::OFS_SRC_SEL, 8'h01);
        far.set_fault(6'h3d);
        chk_drv(5, 4'he);
        far.set_fault(6'h3e);
        chk_drv(5, 4'hc);
        rdc(cwg_pkg::OFS_SHUTDOWN, 8'h80);
        wr(cwg_pkg::OFS_SHUTDOWN, 8'h00);
        rdc(cwg_pkg::OFS_SHUTDOWN, 8'h80);
        far.set_fault(6'h3f);
        chk_drv(5, 4'hc);
        rdc(cwg_pkg::OFS_SHUTDOWN, 8'h80);
        wr(cwg_pkg::OFS_SHUTDOWN, 8'h00);
        rdc(cwg_pkg::OFS_SHUTDOWN, 8'h00);
        chk_drv(1, 4'hc);
        far.set_in(1'b1);
        chk_drv(5, 4'hd);
        far.set_in(1'b0);
        wr(cwg_pkg::OFS_SHUTDOWN, 8'h80);
        chk_drv(4, 4'hc);
    endtask : t_shutdown

    task automatic t_restart;
        int i;
        wr(cwg_pkg::OFS_SHUTDOWN, 8'h40);
        far.set_fault(6'h3e);
        chk_drv(5, 4'hc);
        far.set_fault(6'h3f);
        repeat (5) @(posedge clk);
        rdc(cwg_pkg::OFS_SHUTDOWN, 8'h40);
        chk_drv(1, 4'hc);
        far.set_in(1'b1);
        chk_drv(5, 4'hd);
        far.set_in(1'b0);
        for (i = 1; i < 6; i++)
        begin
            wr(cwg_pkg::OFS_SRC_SEL, 8'h01 << i);
            far.set_fault(6'h3f ^ (6'h01 << i));
            chk_drv(5, 4'hc);
            rdc(cwg_pkg::OFS_SHUTDOWN, 8'hc0);
            far.set_fault(6'h3f);
        end
    endtask : t_restart

    task automatic t_bridge;
        wr(cwg_pkg::OFS_POLARITY, 8'h00);
        start(cwg_pkg::MODE_FB_FWD, 8'h00);
        chk_drv(5, 4'h1);
        wr(cwg_pkg::OFS_PRIMARY, 8'h83);
        chk_drv(5, 4'h1);
        far.set_in(1'b1);
        chk_drv(5, 4'h4);
        chk_drv(20, 4'h6);
        far.set_in(1'b0);
    endtask : t_bridge

    task automatic t_sleep;
        wr(cwg_pkg::OFS_CLK_SEL, 8'h01);
        far.set_in(1'b1);
        repeat (4) @(posedge clk);
        chk_cnt({fast_osc_sel, fast_osc_keep}, 3);
        repeat (30) @(posedge clk);
        chk_cnt({fast_osc_sel, fast_osc_keep}, 2);
        far.set_in(1'b0);
    endtask : t_sleep

    // The start pulse clocks the sequencer once, so B carries the next one.
    task automatic t_push;
        start(cwg_pkg::MODE_PUSH, 8'h00);
        far.pulse(1, 4, d0);
        chk_cnt(d0, 4);
        far.pulse(0, 4, d1);
        chk_cnt(d1, 4);
        wr(cwg_pkg::OFS_PRIMARY, 8'h86);
        far.set_in(1'b1);
        chk_drv(5, 4'h0);
        far.set_in(1'b0);
    endtask : t_push

    //////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        wb_req = '0;
        n_errors = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_deadband();
        t_steer();
        t_shutdown();
        t_restart();
        t_bridge();
        t_sleep();
        t_push();
        close_out();
    end
endmodule : tb_top
